// ---- asc_pkg.sv ----
// constants and types for the serial access and configuration block
package asc_pkg;
	localparam int CFG_W = 16;
	localparam int FRAME_W = 32;
	localparam int CNT_W = 5;
	localparam int SYNC_W = 5;
	localparam logic [15:0] CFG_RESET = 16'h8FCF;
	// configuration word field positions
	localparam int CFG_UPDATE_BIT = 15;
	localparam int CHAN_HI = 14;
	localparam int CHAN_LO = 12;
	localparam int SHARED_REF_BIT = 11;
	localparam int UNUSED_BIT = 10;
	localparam int GAIN_HI = 9;
	localparam int GAIN_LO = 7;
	localparam int PATH_BIT = 6;
	localparam int STEP_HI = 5;
	localparam int STEP_LO = 4;
	localparam int THERM_DIS_BIT = 3;
	localparam int VREF_EN_BIT = 2;
	localparam int MODE_SEL_BIT = 1;
	localparam int PHASE_BIT = 0;
	// serial frame figures
	localparam logic [4:0] CFG_CAPTURE_EDGES = 5'h10;
	localparam logic [4:0] BIT_IDX_FIRST = 5'h00;
	localparam logic [4:0] BIT_IDX_STEP = 5'h01;
	localparam logic [4:0] FRAME_LAST = 5'h1F;
	// synchroniser lanes
	localparam int LANE_CS = 0;
	localparam int LANE_SCK = 1;
	localparam int LANE_DIN = 2;
	localparam int LANE_PD = 3;
	localparam int LANE_RST = 4;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHIFT = 3'b010,
		ST_OFF = 3'b100
	} asc_state_type;
endpackage

// ---- asc_sync.sv ----
// two-flop synchroniser, one lane per pin
`timescale 1ns/1ps
module asc_sync
	import asc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// asynchronous pins and their synchronised copies
	input wire logic [SYNC_W-1:0] async_i,
	output logic [SYNC_W-1:0] sync_o
);
	logic [SYNC_W-1:0] meta_reg;
	logic [SYNC_W-1:0] sync_reg;

	// the first stage feeds only the second stage
	genvar g;
	generate
		for (g = 0; g < SYNC_W; g++)
		begin : g_lane
			always_ff @(posedge clk_sys_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
				begin
					meta_reg[g] <= 1'b0;
					sync_reg[g] <= 1'b0;
				end
				else
				begin
					meta_reg[g] <= async_i[g];
					sync_reg[g] <= meta_reg[g];
				end
			end
		end
	endgenerate

	assign sync_o = sync_reg;
endmodule // asc_sync

// ---- asc_access.sv ----
// serial readout and configuration word pipeline of the acquisition converter
`timescale 1ns/1ps
module asc_access
	import asc_pkg::*;
(
	// system clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// serial pins from the host
	input wire logic chip_select_n_i,
	input wire logic serial_clk_i,
	input wire logic serial_din_i,
	output logic serial_dout_o,
	output logic serial_dout_oe_o,
	// device reset and power-down pins, active high
	input wire logic dev_reset_i,
	input wire logic power_down_i,
	// conversion engine, same clock
	input wire logic conv_done_i,
	input wire logic [CFG_W-1:0] conv_result_i,
	// active configuration fields for the converter
	output logic [CFG_W-1:0] acquisition_config_word_o,
	output logic [2:0] channel_select_o,
	output logic shared_reference_select_o,
	output logic [2:0] amplifier_gain_o,
	output logic input_path_select_o,
	output logic [1:0] channel_stepper_mode_o,
	output logic thermal_sensor_disable_o,
	output logic internal_vref_enable_o,
	output logic conversion_mode_select_o,
	output logic first_bit_phase_o
);
	logic [SYNC_W-1:0] pins_sync;
	logic sck_prev_reg;
	logic cs_n_s;
	logic sck_s;
	logic din_s;
	logic pd_s;
	logic rst_s;
	logic sck_rise;
	logic sck_fall;
	asc_state_type state_reg, state_next;
	logic [CFG_W-1:0] active_cfg_reg, active_cfg_next;
	logic [CFG_W-1:0] pending_cfg_reg, pending_cfg_next;
	logic [CFG_W-1:0] readback_cfg_reg, readback_cfg_next;
	logic [CFG_W-1:0] result_reg, result_next;
	logic [CFG_W-1:0] hold_reg, hold_next;
	logic hold_full_reg, hold_full_next;
	logic [CNT_W-1:0] din_cnt_reg, din_cnt_next;
	logic [CNT_W-1:0] bit_idx_reg, bit_idx_next;
	logic repeat_first_reg, repeat_first_next;
	logic dout_reg, dout_next;
	logic [FRAME_W-1:0] frame;

	// all host pins pass two flops; the serial clock is sampled, not used as a clock
	// select and clock enter inverted so the zero reset of the flops reads as idle high,
	// otherwise reset release would fake a select and a clock edge
	asc_sync u_sync (
		.clk_sys_i(clk_sys_i),
		.reset_n_i(reset_n_i),
		.async_i({dev_reset_i, power_down_i, serial_din_i, ~serial_clk_i, ~chip_select_n_i}),
		.sync_o(pins_sync)
	);

	assign cs_n_s = ~pins_sync[LANE_CS];
	assign sck_s = ~pins_sync[LANE_SCK];
	assign din_s = pins_sync[LANE_DIN];
	assign pd_s = pins_sync[LANE_PD];
	assign rst_s = pins_sync[LANE_RST];
	assign sck_rise = sck_s && !sck_prev_reg;
	assign sck_fall = !sck_s && sck_prev_reg;
	// result first, then its configuration, repeating every 32 falls
	assign frame = {result_reg, readback_cfg_reg};

	// next state of the serial engine and configuration pipeline
	always_comb
	begin
		state_next = state_reg;
		active_cfg_next = active_cfg_reg;
		pending_cfg_next = pending_cfg_reg;
		readback_cfg_next = readback_cfg_reg;
		result_next = result_reg;
		hold_next = hold_reg;
		hold_full_next = hold_full_reg;
		din_cnt_next = din_cnt_reg;
		bit_idx_next = bit_idx_reg;
		repeat_first_next = repeat_first_reg;
		if (rst_s)
		begin
			// device reset pin: defaults back, old result cleared
			state_next = ST_OFF;
			active_cfg_next = CFG_RESET;
			pending_cfg_next = CFG_RESET;
			readback_cfg_next = CFG_RESET;
			result_next = '0;
			hold_full_next = 1'b0;
		end
		else if (pd_s)
		begin
			// power-down keeps the pending, active and readback words; a held word is dropped
			state_next = ST_OFF;
			hold_full_next = 1'b0;
		end
		else
		begin
			if (conv_done_i)
			begin
				// both result and configuration move at conversion end
				result_next = conv_result_i;
				readback_cfg_next = active_cfg_reg;
				active_cfg_next = pending_cfg_reg;
				// a word with the update flag clear changes nothing
				if (hold_full_reg && hold_reg[CFG_UPDATE_BIT])
					pending_cfg_next = hold_reg;
				hold_full_next = 1'b0;
				// fresh data restarts the frame at its first bit
				bit_idx_next = BIT_IDX_FIRST;
				repeat_first_next = active_cfg_reg[PHASE_BIT];
			end
			case (state_reg)
				ST_IDLE, ST_OFF:
				begin
					if (!cs_n_s)
					begin
						state_next = ST_SHIFT;
						bit_idx_next = BIT_IDX_FIRST;
						repeat_first_next = readback_cfg_reg[PHASE_BIT];
						din_cnt_next = '0;
					end
				end
				ST_SHIFT:
				begin
					if (cs_n_s)
						state_next = ST_IDLE;
					else
					begin
						// reads are not blocked during busy; the host keeps the windows
						if (sck_fall && !conv_done_i)
						begin
							if (repeat_first_reg)
								repeat_first_next = 1'b0;
							else
								bit_idx_next = bit_idx_reg + BIT_IDX_STEP;
						end
						// only the first 16 rises of a select period are taken
						if (sck_rise && din_cnt_reg < CFG_CAPTURE_EDGES)
						begin
							hold_next = {hold_reg[CFG_W-2:0], din_s};
							din_cnt_next = din_cnt_reg + BIT_IDX_STEP;
							if (din_cnt_reg == CFG_CAPTURE_EDGES - BIT_IDX_STEP)
								hold_full_next = 1'b1;
						end
					end
				end
				default:
				begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	// serial output bit, registered so the pin never glitches
	always_comb
	begin
		dout_next = frame[FRAME_LAST - bit_idx_next];
	end

	// register the serial engine and the configuration stages
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_reg <= ST_IDLE;
			active_cfg_reg <= CFG_RESET;
			pending_cfg_reg <= CFG_RESET;
			readback_cfg_reg <= CFG_RESET;
			result_reg <= '0;
			hold_reg <= '0;
			hold_full_reg <= 1'b0;
			din_cnt_reg <= '0;
			bit_idx_reg <= BIT_IDX_FIRST;
			repeat_first_reg <= 1'b0;
			dout_reg <= 1'b0;
			sck_prev_reg <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			active_cfg_reg <= active_cfg_next;
			pending_cfg_reg <= pending_cfg_next;
			readback_cfg_reg <= readback_cfg_next;
			result_reg <= result_next;
			hold_reg <= hold_next;
			hold_full_reg <= hold_full_next;
			din_cnt_reg <= din_cnt_next;
			bit_idx_reg <= bit_idx_next;
			repeat_first_reg <= repeat_first_next;
			dout_reg <= dout_next;
			sck_prev_reg <= sck_s;
		end
	end

	// output drives only while selected and powered
	assign serial_dout_o = dout_reg;
	assign serial_dout_oe_o = (state_reg == ST_SHIFT);

	// configuration fields of the word now in force
	assign acquisition_config_word_o = active_cfg_reg;
	assign channel_select_o = active_cfg_reg[CHAN_HI:CHAN_LO];
	assign shared_reference_select_o = active_cfg_reg[SHARED_REF_BIT];
	assign amplifier_gain_o = active_cfg_reg[GAIN_HI:GAIN_LO];
	assign input_path_select_o = active_cfg_reg[PATH_BIT];
	assign channel_stepper_mode_o = active_cfg_reg[STEP_HI:STEP_LO];
	assign thermal_sensor_disable_o = active_cfg_reg[THERM_DIS_BIT];
	assign internal_vref_enable_o = active_cfg_reg[VREF_EN_BIT];
	// the converter picks its timing mode from this bit
	assign conversion_mode_select_o = active_cfg_reg[MODE_SEL_BIT];
	assign first_bit_phase_o = active_cfg_reg[PHASE_BIT];
endmodule // asc_access

// ---- asc_host.sv ----
// host model driving the serial link of the acquisition block
`timescale 1ns/1ps
module asc_host (
	// system clock, used only to pace the link
	input wire logic clk_sys_i,
	// serial pins
	input wire logic serial_dout_i,
	output logic chip_select_n_o,
	output logic serial_clk_o,
	output logic serial_din_o
);
	// link idles with select high and clock high
	initial
	begin
		chip_select_n_o = 1'b1;
		serial_clk_o = 1'b1;
		serial_din_o = 1'b0;
	end
	// one select period of nf falls; hp sets speed; reads each bit before its fall
	task automatic frame(input logic [15:0] w, input int nf, input int hp, output logic [32:0] rd);
		rd = '0;
		@(posedge clk_sys_i);
		chip_select_n_o <= 1'b0;
		// quiet gap after select stands in for the aperture delay
		repeat (8) @(posedge clk_sys_i);
		for (int i = 0; i < nf; i++)
		begin
			// split burst: clock paused while select stays low
			if (i == 16)
				repeat (12) @(posedge clk_sys_i);
			rd = {rd[31:0], serial_dout_i};
			serial_clk_o <= 1'b0;
			serial_din_o <= (i < 16) ? w[15 - i] : ~serial_din_o;
			repeat (hp) @(posedge clk_sys_i);
			serial_clk_o <= 1'b1;
			repeat (hp) @(posedge clk_sys_i);
		end
		// all activity ends with the frame; released data line must not keep its last value
		chip_select_n_o <= 1'b1;
		serial_din_o <= ~serial_din_o;
		repeat (8) @(posedge clk_sys_i);
	endtask
endmodule // asc_host

// ---- asc_access_chk.sv ----
// concurrent checks on the ports of the serial access block
`timescale 1ns/1ps
module asc_access_chk
	import asc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	// watched pins
	input wire logic chip_select_n_i,
	input wire logic serial_clk_i,
	input wire logic serial_dout_o,
	input wire logic serial_dout_oe_o,
	input wire logic dev_reset_i,
	input wire logic power_down_i,
	input wire logic conv_done_i,
	input wire logic [CFG_W-1:0] acquisition_config_word_o,
	input wire logic [2:0] channel_select_o,
	input wire logic first_bit_phase_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	// sync latency is covered by five cycles of held pin
	a_oe_reset: assert property (dev_reset_i [*5] |-> !serial_dout_oe_o)
		else $error("output driven in reset");
	a_cfg_default: assert property (dev_reset_i [*5] |-> acquisition_config_word_o == CFG_RESET)
		else $error("reset word wrong");
	a_cfg_quiet: assert property ((!conv_done_i && !dev_reset_i) [*4] |=> $stable(acquisition_config_word_o))
		else $error("word moved without conversion end");
	a_pd_keeps: assert property ((power_down_i && !dev_reset_i) [*3] |=> $stable(acquisition_config_word_o))
		else $error("power-down changed word");
	a_field_map: assert property (channel_select_o == acquisition_config_word_o[CHAN_HI:CHAN_LO]
		&& first_bit_phase_o == acquisition_config_word_o[PHASE_BIT])
		else $error("field map wrong");
	a_oe_on_cs: assert property ($rose(serial_dout_oe_o) |-> !chip_select_n_i && !$past(chip_select_n_i, 2))
		else $error("output enabled without select");
	a_oe_release: assert property ($rose(chip_select_n_i) |-> ##[1:6] !serial_dout_oe_o)
		else $error("output not released");
	a_dout_hold: assert property ((!chip_select_n_i && $stable(serial_clk_i) && !conv_done_i) [*6]
		|=> $stable(serial_dout_o))
		else $error("output moved without fall");
	cover property ($rose(serial_dout_oe_o));
	cover property (conv_done_i);
	cover property (dev_reset_i [*5]);
endmodule // asc_access_chk
bind asc_access asc_access_chk asc_access_chk_i (.*);

// ---- tb_adc_serial_access_config.sv ----
// self-checking bench for the serial access and configuration block
`timescale 1ns/1ps
`define CK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; $display("unexpected %0t %h %h", $time, a, b); end end
module tb_adc_serial_access_config;
	import asc_pkg::*;
	logic clk_sys_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic dev_reset_i = 1'b0;
	logic power_down_i = 1'b0;
	logic conv_done_i = 1'b0;
	logic [CFG_W-1:0] conv_result_i = 16'h0000;
	logic cs_n, sck, din, dout, phase;
	logic [CFG_W-1:0] cfg;
	logic [2:0] chan;
	logic sref, path, therm, vref, mode;
	logic [2:0] gain;
	logic [1:0] step;
	logic [13:0] flds;
	logic [32:0] rd;
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;
	always #2 clk_sys_i = ~clk_sys_i;
	asc_host asc_host_i (.clk_sys_i(clk_sys_i), .serial_dout_i(dout), .chip_select_n_o(cs_n),
		.serial_clk_o(sck), .serial_din_o(din));
	asc_access asc_access_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .chip_select_n_i(cs_n),
		.serial_clk_i(sck), .serial_din_i(din), .serial_dout_o(dout), .serial_dout_oe_o(),
		.dev_reset_i(dev_reset_i), .power_down_i(power_down_i), .conv_done_i(conv_done_i),
		.conv_result_i(conv_result_i), .acquisition_config_word_o(cfg), .channel_select_o(chan),
		.shared_reference_select_o(sref), .amplifier_gain_o(gain), .input_path_select_o(path),
		.channel_stepper_mode_o(step), .thermal_sensor_disable_o(therm), .internal_vref_enable_o(vref),
		.conversion_mode_select_o(mode), .first_bit_phase_o(phase));
	// every field output in word order, the unused bit left out
	assign flds = {chan, sref, gain, path, step, therm, vref, mode, phase};
	// one end-of-conversion pulse carrying result r, only while select is high
	task automatic conv(input logic [15:0] r);
		@(posedge clk_sys_i);
		conv_done_i <= 1'b1;
		conv_result_i <= r;
		@(posedge clk_sys_i);
		conv_done_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// hang guard, far above the few thousand cycles the tests need
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_fail++;
			conclude();
		end
	end
	initial
	begin
		repeat (2) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		`CK(cfg, CFG_RESET)
		`CK(chan, 3'h0)
		`CK(flds, {CFG_RESET[CHAN_HI:SHARED_REF_BIT], CFG_RESET[GAIN_HI:PHASE_BIT]})
		$display("reset test done");
		// word written now is active two conversions on, read back a third on
		// default readback has phase 1, so the result's top bit comes twice
		conv(16'h1234);
		asc_host_i.frame(16'hB2A4, 32, 4, rd);
		`CK(rd, {1'b0, 1'b0, 16'h1234, CFG_RESET[15:1]})
		conv(16'hFEDC);
		asc_host_i.frame(16'h3000, 32, 6, rd);
		`CK(rd, {1'b0, 1'b1, 16'hFEDC, CFG_RESET[15:1]})
		conv(16'h0F0F);
		`CK(cfg, 16'hB2A4)
		`CK(chan, 3'h3)
		`CK(flds, 14'h1AA4)
		asc_host_i.frame(16'hC0C5, 32, 4, rd);
		`CK(rd, {1'b0, 1'b0, 16'h0F0F, CFG_RESET[15:1]})
		conv(16'h8001);
		`CK(cfg, 16'hB2A4)
		asc_host_i.frame(16'h0000, 32, 4, rd);
		`CK(rd, {1'b0, 16'h8001, 16'hB2A4})
		conv(16'h5AA5);
		`CK(phase, 1'b1)
		asc_host_i.frame(16'h0000, 32, 4, rd);
		`CK(rd, {1'b0, 16'h5AA5, 16'hB2A4})
		conv(16'hA55A);
		// flag-clear word leaves ones in the low half of the holding register
		asc_host_i.frame(16'h00FF, 33, 4, rd);
		`CK(rd, {1'b1, 16'hA55A, 16'hC0C5})
		$display("pipeline test done");
		power_down_i <= 1'b1;
		repeat (10) @(posedge clk_sys_i);
		power_down_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		`CK(cfg, 16'hC0C5)
		dev_reset_i <= 1'b1;
		repeat (10) @(posedge clk_sys_i);
		dev_reset_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		`CK(cfg, CFG_RESET)
		// a short write of eight bits must be thrown away; taken wrongly it would
		// leave a word with the update flag set in the holding register
		asc_host_i.frame(16'h9111, 8, 4, rd);
		conv(16'h0001);
		conv(16'h0002);
		`CK(cfg, CFG_RESET)
		$display("reset and power-down test done");
		conclude();
	end
endmodule // tb_adc_serial_access_config
